// ===== oscs_pkg.sv
// Package of constants, types and register layout for the oscillator select control
// Summary of operation
// - Decode 110/101/100 as LPFRC-div, LOW_POWER_RC_OSC, secondary
// - Decode 010 as primary oscillator without PLL
// - Decode 001 as fast RC, postscaler, PLL
// - Monitor on and lock set: ignore selection changes
// - Lock clear: switch request changes selection
// - Monitor off: lock ignored, switching always allowed
// - PLL lock forced 0 on switch, non-PLL mode
// - Bit 1 turns secondary oscillator on, or off when it is not the current source
// - Writing switch request starts switch to selection
// - Switch request reads 0 once switch done
// - Reset loads selection from configuration bits
// - Clock fail flag readable, clear-only, cleared on switch
// - Switch request auto-clears on success, redundant, fallback
package oscs_pkg;
	// Register word indexes (byte address is four times these)
	localparam logic [1:0] OSCS_IDX_CTRL = 2'h0;
	localparam logic [1:0] OSCS_IDX_STAT = 2'h1;
	localparam logic [1:0] OSCS_IDX_CLR = 2'h2;
	localparam logic [1:0] OSCS_IDX_EN = 2'h3;
	localparam logic [1:0] OSCS_IDX_UNLOCK = 2'h0;
	// Unlock keys written to the unlock word
	localparam logic [15:0] OSCS_KEY1 = 16'h0046;
	localparam logic [15:0] OSCS_KEY2 = 16'h0057;
	// Control register field positions
	localparam int OSCS_B_SWREQ = 0;
	localparam int OSCS_B_SECONDARY_OSC_ENABLE = 1;
	localparam int OSCS_B_CF = 3;
	localparam int OSCS_B_LOCK = 5;
	localparam int OSCS_B_CLOCK_LOCK = 7;
	localparam int OSCS_B_NEW_SOURCE_SELECT = 8;
	localparam int OSCS_B_CURRENT_SOURCE_SELECT = 12;
	// Event bits in status, clear and enable words
	localparam int OSCS_EV_DONE = 0;
	localparam int OSCS_EV_FAIL = 1;
	localparam int OSCS_EV_PLLLOCK = 2;
	localparam int OSCS_NEV = 3;
	// Switch settle time and its cycle count at 100 MHz
	localparam int OSCS_CLK_MHZ = 100;
	localparam int OSCS_SETTLE_NS = 100;
	localparam logic [7:0] OSCS_SETTLE_CYC = 8'((OSCS_SETTLE_NS * OSCS_CLK_MHZ + 999) / 1000);
	localparam logic [7:0] OSCS_ZERO8 = 8'h00;
	// Source selection codes
	typedef enum logic [2:0] {
		OSCS_FAST_RC_OSC = 3'h0,
		OSCS_FAST_RC_POSTSCALER_PLL = 3'h1,
		OSCS_PRIMARY_DIRECT = 3'h2,
		OSCS_PRIMARY_PLL = 3'h3,
		OSCS_SECONDARY_OSC = 3'h4,
		OSCS_LOW_POWER_RC_OSC = 3'h5,
		OSCS_LP_FAST_RC_WITH_POSTSCALER = 3'h6,
		OSCS_FAST_RC_WITH_POSTSCALER = 3'h7
	} oscs_src_type;
	// Decoded oscillator enables for the analog side
	typedef struct packed {
		logic fast_rc_en;
		logic lp_fast_rc_en;
		logic low_power_rc_en;
		logic secondary_en;
		logic primary_en;
		logic pll_en;
		logic postscaler_en;
	} oscs_dec_type;
endpackage

// ===== oscs_decode.sv
// Source code decoder for the oscillator select control
`timescale 1ns/1ns
module oscs_decode (
	input wire oscs_pkg::oscs_src_type src,
	output oscs_pkg::oscs_dec_type dec
);
	// Purely combinational; a code maps to the oscillators it needs
	always_comb begin
		dec = '0;
		case (src)
			oscs_pkg::OSCS_LP_FAST_RC_WITH_POSTSCALER: begin
				dec.lp_fast_rc_en = 1'b1;
				dec.postscaler_en = 1'b1;
			end
			oscs_pkg::OSCS_LOW_POWER_RC_OSC: begin
				dec.low_power_rc_en = 1'b1;
			end
			oscs_pkg::OSCS_SECONDARY_OSC: begin
				dec.secondary_en = 1'b1;
			end
			oscs_pkg::OSCS_PRIMARY_PLL: begin
				dec.primary_en = 1'b1;
				dec.pll_en = 1'b1;
			end
			oscs_pkg::OSCS_PRIMARY_DIRECT: begin
				dec.primary_en = 1'b1;
			end
			oscs_pkg::OSCS_FAST_RC_POSTSCALER_PLL: begin
				dec.fast_rc_en = 1'b1;
				dec.postscaler_en = 1'b1;
				dec.pll_en = 1'b1;
			end
			oscs_pkg::OSCS_FAST_RC_WITH_POSTSCALER: begin
				dec.fast_rc_en = 1'b1;
				dec.postscaler_en = 1'b1;
			end
			default: begin
				dec.fast_rc_en = 1'b1;
			end
		endcase
	end
endmodule

// ===== oscs_ctrl.sv
// Oscillator select control: registers, switch sequencing and status
`timescale 1ns/1ns
module oscs_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Configuration and oscillator status inputs
	input wire logic [2:0] reset_source_config,
	input wire logic fail_safe_monitor_cfg,
	input wire logic pll_locked,
	input wire logic clock_fail_detect,
	// Oscillator controls
	output oscs_pkg::oscs_dec_type osc_dec,
	output logic [2:0] current_source_select,
	output logic secondary_osc_enable,
	output logic irq
);
	// Switch sequencer states
	typedef enum logic [1:0] {
		OSCS_ST_CFG,
		OSCS_ST_IDLE,
		OSCS_ST_SETTLE
	} oscs_st_type;

	// All state of the block
	typedef struct packed {
		oscs_st_type st;
		logic [2:0] new_src;
		logic [2:0] cur_src;
		logic clock_lock;
		logic secondary_osc_en;
		logic cf;
		logic swreq;
		logic [7:0] cnt;
		logic [1:0] unlock;
		logic [oscs_pkg::OSCS_NEV-1:0] ev_stat;
		logic [oscs_pkg::OSCS_NEV-1:0] ev_en;
		logic lock_q;
		logic ack;
		logic [31:0] rdata;
	} oscs_state_type;

	oscs_state_type s_r; // Registered state
	oscs_state_type s_nxt; // Next state
	oscs_pkg::oscs_dec_type cur_dec; // Decode of active source
	logic lock_bit; // Live PLL lock status
	logic sel_ok; // Selection may change
	logic [15:0] ctrl_word; // Control register image
	logic wr_ctrl; // Accepted control write
	logic [oscs_pkg::OSCS_NEV-1:0] ev_set; // Event pulses
	logic cf_rise; // Failure flag newly set
	logic lo_page; // Words 0 to 3: the mapped registers
	logic key_page; // Words 4 to 7: unlock key word lives here

	// Upper address bits must be decoded, else words 4 to 15 alias the registers
	assign lo_page = (avs_address[3:2] == 2'h0);
	assign key_page = (avs_address[3:2] == 2'h1);

	// Decoder of the active source drives the oscillator enables
	oscs_decode u_dec (
		.src(oscs_pkg::oscs_src_type'(s_r.cur_src)),
		.dec(cur_dec)
	);

	// PLL lock reads zero in non-PLL modes and while switching
	assign lock_bit = pll_locked && cur_dec.pll_en && (s_r.st == OSCS_ST_IDLE);
	// Lock only counts when the monitor is configured on
	assign sel_ok = !(fail_safe_monitor_cfg && s_r.clock_lock);
	assign wr_ctrl = avs_write && !s_r.ack && (avs_address[1:0] == oscs_pkg::OSCS_IDX_CTRL)
		&& lo_page && (s_r.unlock == 2'h2);
	assign cf_rise = clock_fail_detect && !s_r.cf;

	// Control word; unimplemented bits stay zero
	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[oscs_pkg::OSCS_B_CURRENT_SOURCE_SELECT +: 3] = s_r.cur_src;
		ctrl_word[oscs_pkg::OSCS_B_NEW_SOURCE_SELECT +: 3] = s_r.new_src;
		ctrl_word[oscs_pkg::OSCS_B_CLOCK_LOCK] = s_r.clock_lock;
		ctrl_word[oscs_pkg::OSCS_B_LOCK] = lock_bit;
		ctrl_word[oscs_pkg::OSCS_B_CF] = s_r.cf;
		ctrl_word[oscs_pkg::OSCS_B_SECONDARY_OSC_ENABLE] = s_r.secondary_osc_en;
		ctrl_word[oscs_pkg::OSCS_B_SWREQ] = s_r.swreq;
	end

	// Next state: bus, unlock, switch sequencing, events
	always_comb begin
		s_nxt = s_r;
		ev_set = '0;
		s_nxt.ack = 1'b0;
		s_nxt.lock_q = lock_bit;
		if (lock_bit && !s_r.lock_q) begin
			ev_set[oscs_pkg::OSCS_EV_PLLLOCK] = 1'b1;
		end
		// Hardware sets the failure flag; set beats a clear
		if (cf_rise) begin
			ev_set[oscs_pkg::OSCS_EV_FAIL] = 1'b1;
		end
		// One wait cycle per access; answer on the second edge
		if ((avs_read || avs_write) && !s_r.ack) begin
			s_nxt.ack = 1'b1;
			s_nxt.rdata = 32'h0000_0000;
			case (avs_address[1:0])
				oscs_pkg::OSCS_IDX_CTRL: s_nxt.rdata[15:0] = lo_page ? ctrl_word : 16'h0000;
				oscs_pkg::OSCS_IDX_STAT: s_nxt.rdata[oscs_pkg::OSCS_NEV-1:0] = lo_page ? s_r.ev_stat : '0;
				oscs_pkg::OSCS_IDX_EN: s_nxt.rdata[oscs_pkg::OSCS_NEV-1:0] = lo_page ? s_r.ev_en : '0;
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Unlock sequence lives at word 4; any other write rearms it
		if (avs_write && !s_r.ack) begin
			if (key_page && avs_address[1:0] == oscs_pkg::OSCS_IDX_UNLOCK) begin
				if (avs_writedata[15:0] == oscs_pkg::OSCS_KEY1) begin
					s_nxt.unlock = 2'h1;
				end else if (avs_writedata[15:0] == oscs_pkg::OSCS_KEY2 && s_r.unlock == 2'h1) begin
					s_nxt.unlock = 2'h2;
				end else begin
					s_nxt.unlock = 2'h0;
				end
			end else begin
				s_nxt.unlock = 2'h0;
			end
			if (lo_page && avs_address[1:0] == oscs_pkg::OSCS_IDX_EN) begin
				s_nxt.ev_en = avs_writedata[oscs_pkg::OSCS_NEV-1:0];
			end
			if (lo_page && avs_address[1:0] == oscs_pkg::OSCS_IDX_CLR) begin
				s_nxt.ev_stat = s_r.ev_stat & ~avs_writedata[oscs_pkg::OSCS_NEV-1:0];
			end
		end
		// Control write after a good unlock
		if (wr_ctrl) begin
			s_nxt.secondary_osc_en = avs_writedata[oscs_pkg::OSCS_B_SECONDARY_OSC_ENABLE];
			if (!avs_writedata[oscs_pkg::OSCS_B_CF]) begin
				s_nxt.cf = 1'b0;
			end
			if (avs_writedata[oscs_pkg::OSCS_B_CLOCK_LOCK]) begin
				s_nxt.clock_lock = 1'b1;
			end
			if (sel_ok) begin
				s_nxt.new_src = avs_writedata[oscs_pkg::OSCS_B_NEW_SOURCE_SELECT +: 3];
				if (avs_writedata[oscs_pkg::OSCS_B_SWREQ] && s_r.st == OSCS_ST_IDLE) begin
					s_nxt.swreq = 1'b1;
				end
			end
		end
		if (cf_rise) begin
			s_nxt.cf = 1'b1;
		end
		// Switch sequencer
		case (s_r.st)
			OSCS_ST_CFG: begin
				s_nxt.new_src = reset_source_config;
				s_nxt.cur_src = reset_source_config;
				s_nxt.st = OSCS_ST_IDLE;
			end
			OSCS_ST_IDLE: begin
				if (s_r.swreq) begin
					s_nxt.cnt = oscs_pkg::OSCS_SETTLE_CYC;
					s_nxt.st = OSCS_ST_SETTLE;
				end
			end
			OSCS_ST_SETTLE: begin
				if (s_r.cnt != oscs_pkg::OSCS_ZERO8) begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end else begin
					// Completion, redundant or fallback alike
					s_nxt.cur_src = s_r.new_src;
					s_nxt.swreq = 1'b0;
					if (!cf_rise) begin
						s_nxt.cf = 1'b0;
					end
					ev_set[oscs_pkg::OSCS_EV_DONE] = 1'b1;
					s_nxt.st = OSCS_ST_IDLE;
				end
			end
			default: s_nxt.st = OSCS_ST_CFG;
		endcase
		// Fail-safe fallback to the fast RC oscillator
		if (cf_rise && fail_safe_monitor_cfg && s_r.st != OSCS_ST_CFG) begin
			s_nxt.new_src = oscs_pkg::OSCS_FAST_RC_OSC;
			s_nxt.swreq = 1'b1;
			if (s_r.st == OSCS_ST_IDLE) begin
				s_nxt.cnt = oscs_pkg::OSCS_SETTLE_CYC;
				s_nxt.st = OSCS_ST_SETTLE;
			end
		end
		// Events win over software clears
		s_nxt.ev_stat = s_nxt.ev_stat | ev_set;
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
	assign avs_readdata = s_r.rdata;
	assign osc_dec = cur_dec;
	assign current_source_select = s_r.cur_src;
	assign secondary_osc_enable = s_r.secondary_osc_en || cur_dec.secondary_en;
	assign irq = |(s_r.ev_stat & s_r.ev_en);

	// Lock bit never shows outside idle
	a_lock_in_switch: assert property (@(posedge core_clk) disable iff (rst)
		(s_r.st == OSCS_ST_SETTLE) |-> !ctrl_word[oscs_pkg::OSCS_B_LOCK]) else $error("lock high during switch");
	a_lock_nonpll: assert property (@(posedge core_clk) disable iff (rst)
		!cur_dec.pll_en |-> !ctrl_word[oscs_pkg::OSCS_B_LOCK]) else $error("lock high in non-PLL mode");
	a_locked_sel: assert property (@(posedge core_clk) disable iff (rst)
		(fail_safe_monitor_cfg && s_r.clock_lock && wr_ctrl) |=> $stable(s_r.new_src)) else $error("locked selection changed");
	a_switch_clears: assert property (@(posedge core_clk) disable iff (rst)
		(s_r.st == OSCS_ST_IDLE && s_r.swreq && !cf_rise) |-> ##[1:300] !s_r.swreq) else $error("switch never done");
	a_cur_copy: assert property (@(posedge core_clk) disable iff (rst)
		$fell(s_r.swreq) |-> s_r.cur_src == $past(s_r.new_src)) else $error("current source not copied");
	a_start_switch: assert property (@(posedge core_clk) disable iff (rst)
		(wr_ctrl && sel_ok && avs_writedata[oscs_pkg::OSCS_B_SWREQ] && s_r.st == OSCS_ST_IDLE) |=> s_r.swreq)
		else $error("switch not started");
	a_secondary_osc_follow: assert property (@(posedge core_clk) disable iff (rst)
		wr_ctrl |=> s_r.secondary_osc_en == $past(avs_writedata[oscs_pkg::OSCS_B_SECONDARY_OSC_ENABLE])) else $error("secondary_osc enable wrong");
	a_cf_cleared: assert property (@(posedge core_clk) disable iff (rst)
		($fell(s_r.swreq) && !$past(cf_rise)) |-> !s_r.cf) else $error("fail flag not cleared");
	a_reset_cfg: assert property (@(posedge core_clk) disable iff (rst)
		(s_r.st == OSCS_ST_CFG) |=> s_r.new_src == $past(reset_source_config)) else $error("config not loaded");
	a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst)
		(ctrl_word[15] | ctrl_word[11] | ctrl_word[6] | ctrl_word[4] | ctrl_word[2]) == 1'b0) else $error("unimplemented bit set");
endmodule

// ===== oscillator_select_control_tb.sv
// Self-checking testbench for the oscillator select control
`timescale 1ns/1ns
module oscillator_select_control_tb;
	logic core_clk = 1'b0; // Bench clock, 100 MHz
	logic rst = 1'b1; // Held high from time zero
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [2:0] reset_source_config = 3'h2; // Strap loaded after reset
	logic fail_safe_monitor_cfg = 1'b0;
	logic pll_locked = 1'b1;
	logic clock_fail_detect = 1'b0;
	oscs_pkg::oscs_dec_type osc_dec;
	logic [2:0] current_source_select;
	logic secondary_osc_enable;
	logic irq;
	int bad_count = 0; // Mismatches
	int check_count = 0; // Comparisons made
	logic [31:0] d; // Last word read
	logic [2:0] c; // Source under test

	// Clock
	always #5 core_clk = ~core_clk;

	oscs_ctrl i_dut (
		.core_clk(core_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.reset_source_config(reset_source_config),
		.fail_safe_monitor_cfg(fail_safe_monitor_cfg),
		.pll_locked(pll_locked),
		.clock_fail_detect(clock_fail_detect),
		.osc_dec(osc_dec),
		.current_source_select(current_source_select),
		.secondary_osc_enable(secondary_osc_enable),
		.irq(irq)
	);

	// Verdict and end of run
	task automatic end_of_test;
		if (bad_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Word compare, four-state
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// One Avalon access; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {16'h0, wd};
		// Sampled at the rising edge, before that edge's updates land
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			chk("waitrequest", 32'h0, 32'h1);
		end
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		bus(1'b0, a, 16'h0);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		bus(1'b1, a, v);
	endtask

	// Key pair right before the control write, else it is dropped
	task automatic ctl(input logic [15:0] v);
		wr(4'h4, oscs_pkg::OSCS_KEY1);
		wr(4'h4, oscs_pkg::OSCS_KEY2);
		wr(4'h0, v);
	endtask

	// Switch request; fail flag written 1 so software never clears it here
	task automatic sw(input logic [2:0] s);
		int n;
		n = 0;
		ctl({5'h0, s, 8'h09});
		do begin
			rd(4'h0);
			n++;
		end while (d[0] !== 1'b0 && n < 40);
		chk("switch_request", 32'h0, 32'(d[0]));
	endtask

	// Expected source enables
	function automatic oscs_pkg::oscs_dec_type exp_dec(input logic [2:0] s);
		oscs_pkg::oscs_dec_type e;
		e = '0;
		e.fast_rc_en = (s == 3'h0 || s == 3'h1 || s == 3'h7);
		e.lp_fast_rc_en = (s == 3'h6);
		e.low_power_rc_en = (s == 3'h5);
		e.secondary_en = (s == 3'h4);
		e.primary_en = (s == 3'h2 || s == 3'h3);
		e.pll_en = (s == 3'h1 || s == 3'h3);
		e.postscaler_en = (s == 3'h1 || s == 3'h6 || s == 3'h7);
		return e;
	endfunction

	// Reset for six cycles; first request three edges after release
	task automatic rst_dut(input logic [2:0] s);
		reset_source_config <= s;
		rst <= 1'b1;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	// Main sequence
	initial begin
		rst_dut(3'h2);
		rd(4'h0);
		chk("ctrl_reset", 32'h2200, d);
		rd(4'h5);
		chk("unmapped", 32'h0, d);
		wr(4'h0, 16'h0202);
		rd(4'h0);
		chk("ctrl_no_unlock", 32'h2200, d);
		// Unused bits written 1 must stay 0
		ctl(16'h8a56);
		rd(4'h0);
		chk("ctrl_secondary_osc", 32'h2202, d);
		chk("secondary_osc_out", 32'h1, 32'(secondary_osc_enable));
		wr(4'h3, 16'h0007);
		rd(4'h3);
		chk("irq_enable", 32'h7, d);
		// Every source code, last one a redundant switch
		for (int i = 0; i < 9; i++) begin
			c = (i > 7) ? 3'h7 : 3'(i);
			sw(c);
			chk("ctrl_switch", {17'h0, c, 1'b0, c, 2'h0, (c == 3'h1 || c == 3'h3), 5'h0}, d);
			chk("osc_dec", 32'(exp_dec(c)), 32'(osc_dec));
			chk("current_src", 32'(c), 32'(current_source_select));
			chk("secondary_osc_out", 32'(c == 3'h4), 32'(secondary_osc_enable));
			rd(4'h1);
			chk("done_event", 32'h1, 32'(d[0]));
			chk("irq_set", 32'h1, 32'(irq));
			wr(4'h2, 16'h0007);
			rd(4'h1);
			chk("done_clear", 32'h0, 32'(d[0]));
			chk("irq_clear", 32'h0, 32'(irq));
		end
		// Masked event with the PLL out of lock
		wr(4'h3, 16'h0000);
		pll_locked <= 1'b0;
		sw(3'h3);
		chk("ctrl_pll_unlocked", 32'h3300, d);
		rd(4'h1);
		chk("done_masked", 32'h1, 32'(d[0]));
		chk("irq_masked", 32'h0, 32'(irq));
		pll_locked <= 1'b1;
		rd(4'h0);
		chk("ctrl_pll_lock", 32'h3320, d);
		wr(4'h2, 16'h0007);
		// Fail flag: set by hardware, cleared by software, never set by it
		clock_fail_detect <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(4'h0);
		chk("cf_set", 32'h3328, d);
		clock_fail_detect <= 1'b0;
		ctl(16'h0300);
		rd(4'h0);
		chk("cf_clear", 32'h3320, d);
		ctl(16'h0308);
		rd(4'h0);
		chk("cf_no_set", 32'h3320, d);
		clock_fail_detect <= 1'b1;
		repeat (4) @(posedge core_clk);
		clock_fail_detect <= 1'b0;
		sw(3'h3);
		chk("cf_switch_clear", 32'h3320, d);
		// Lock bit with the monitor off, then on
		ctl(16'h0388);
		rd(4'h0);
		chk("clock_lock", 32'h33a0, d);
		sw(3'h5);
		chk("lock_ignored", 32'h5580, d);
		fail_safe_monitor_cfg <= 1'b1;
		sw(3'h6);
		chk("lock_held", 32'h5580, d);
		// Monitor fall-back to the fast RC source
		// Short failure pulse, so the finished fall-back does not set the flag again
		clock_fail_detect <= 1'b1;
		repeat (2) @(posedge core_clk);
		clock_fail_detect <= 1'b0;
		repeat (20) @(posedge core_clk);
		rd(4'h0);
		chk("fallback", 32'h0, 32'({d[14:12], d[0]}));
		fail_safe_monitor_cfg <= 1'b0;
		// Second reset with another strap
		rst_dut(3'h5);
		rd(4'h0);
		chk("ctrl_reset2", 32'h5500, d);
		end_of_test;
	end

	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		bad_count++;
		end_of_test;
	end
endmodule
